// ==== core/shc_shutter_controller.sv ====
`timescale 1ns/1ps
// Functional notes
// - shutter stays open while the open/close input is low, closes once high.
// - falling edge starts opening, rising edge starts closing.
// - first-blade-closed output active low when first blade rests in aperture.
// - second-blade-closed output active low when second blade rests in aperture.
// - active-low fault output on fatal error; cause readable in status byte.
// - after fatal error exposures blocked until reset button or restart command.
// - serial port is 19200 baud, 8 data bits, 1 stop, no parity.
// - new exposure starts only after the shutter is fully closed.
// - open/close transitions during closing are ignored.
// - open button opens the shutter while held, closes on release.
// - timed exposure command runs one full open-close cycle of given milliseconds.
// - falling edge of the exposure input detected within about 20 us.
// - interlock lamp lit while the mechanics cable is not secured.
// - separate fault lamps for comms, first drive and second drive.
// - reset button resets both drive controllers and the comms controller.
// - mismatch of steps and encoder counts beyond limit (default 24) is fatal.
module shc_shutter_controller #(
   parameter int BAUD_CYC = shc_pkg::BAUD_CYC,
   parameter int STEP_CYC = shc_pkg::STEP_CYC,
   parameter int MS_CYC   = shc_pkg::MS_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   // camera control lines
   input  wire logic        i_open_close_n,
   output logic             o_first_closed_n,
   output logic             o_second_closed_n,
   output logic             o_fault_n,
   // front panel
   input  wire logic        i_open_btn,
   input  wire logic        i_reset_btn,
   input  wire logic        i_cable_secure,
   output shc_pkg::shc_lamps_t o_lamps,
   // blade drives and encoders
   output logic [1:0]       o_step,
   output logic             o_dir,
   input  wire logic [1:0]  i_enc_pulse,
   // serial port
   input  wire logic        i_rxd,
   output logic             o_txd
);

   typedef struct packed
   {
      shc_pkg::shc_state_t st;
      logic        lead;
      logic        dir;
      logic [13:0] sdiv;
      logic [12:0] steps;
      logic [12:0] enc;
      logic [1:0]  step;
      logic [7:0]  limit;
      logic        fatal;
      logic [1:0]  derr;
      logic        cerr;
      logic        ilk;
      logic        ctl_prev;
      logic        btn_prev;
      logic        timed;
      logic [17:0] mdiv;
      logic [15:0] ms;
      logic [1:0]  pst;
      logic [7:0]  phi;
      logic        txv;
      logic [7:0]  txb;
      logic [1:0]  cl_n;
   } shc_top_t;

   // distance between commanded and counted steps
   function automatic logic [12:0] shc_gap(input logic [12:0] a, input logic [12:0] b);
      shc_gap = (a > b) ? a - b : b - a;
   endfunction

   shc_top_t q;
   shc_top_t d;

   logic               ctl_lvl;
   logic               btn_lvl;
   logic               rst_lvl;
   logic               tx_ready;
   logic               ferr;
   shc_pkg::shc_byte_t rx;
   shc_pkg::shc_byte_t tx;
   logic               restart;
   logic               ctl_fall;
   logic               btn_rise;
   logic               open_lvl;
   logic               mv;
   logic               moving;
   logic [7:0]         sbyte;

   // filtered panel and control inputs
   shc_filter #(.RST_LVL(1'b1)) u_ctl_flt
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_raw    (i_open_close_n),
      .o_lvl    (ctl_lvl)
   );

   shc_filter #(.RST_LVL(1'b0)) u_btn_flt
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_raw    (i_open_btn),
      .o_lvl    (btn_lvl)
   );

   shc_filter #(.RST_LVL(1'b0)) u_rst_flt
   (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_raw    (i_reset_btn),
      .o_lvl    (rst_lvl)
   );

   // host serial port
   shc_uart #(.BAUD_CYC(BAUD_CYC)) u_uart
   (
      .i_clk       (i_clk),
      .i_arst_n    (i_arst_n),
      .i_rxd       (i_rxd),
      .o_txd       (o_txd),
      .o_rx        (rx),
      .o_frame_err (ferr),
      .i_tx        (tx),
      .o_tx_ready  (tx_ready)
   );

   // edges, open request and status byte
   assign ctl_fall = q.ctl_prev & !ctl_lvl;
   assign btn_rise = !q.btn_prev & btn_lvl;
   assign open_lvl = !ctl_lvl | btn_lvl | q.timed;
   assign restart  = rst_lvl
                   | (rx.valid && q.pst == 2'h0 && rx.data == shc_pkg::CMD_RESTART);
   assign moving   = (q.st == shc_pkg::ST_OPENING) || (q.st == shc_pkg::ST_CLOSING);
   assign mv       = (q.st == shc_pkg::ST_OPENING) ? q.lead : !q.lead;

   always_comb
   begin
      sbyte = 8'h00;
      sbyte[shc_pkg::SB_FATAL] = q.fatal;
      sbyte[shc_pkg::SB_DRV1]  = q.derr[0];
      sbyte[shc_pkg::SB_DRV2]  = q.derr[1];
      sbyte[shc_pkg::SB_COMM]  = q.cerr;
      sbyte[shc_pkg::SB_OPEN]  = (q.st == shc_pkg::ST_OPEN);
      sbyte[shc_pkg::SB_LEAD]  = q.lead;
   end

   // next state: commands, motion, checks
   always_comb
   begin
      d = q;
      d.step = 2'b00;
      d.ctl_prev = ctl_lvl;
      d.btn_prev = btn_lvl;
      d.ilk = !i_cable_secure;
      if (q.txv && tx_ready)
         d.txv = 1'b0;
      // command parser
      if (rx.valid)
      begin
         case (q.pst)
            2'h0:
            begin
               if (rx.data == shc_pkg::CMD_TIMED_EXPO)
                  d.pst = 2'h1;
               else if (rx.data == shc_pkg::CMD_LIMIT)
                  d.pst = 2'h3;
               else if (rx.data == shc_pkg::CMD_STATUS)
               begin
                  d.txv = 1'b1;
                  d.txb = sbyte;
               end
               else if (rx.data != shc_pkg::CMD_RESTART)
               begin
                  d.cerr = 1'b1;
                  d.txv = 1'b1;
                  d.txb = shc_pkg::REPLY_UNKNOWN;
               end
            end
            2'h1:
            begin
               d.phi = rx.data;
               d.pst = 2'h2;
            end
            2'h2:
            begin
               d.pst = 2'h0;
               if (q.st == shc_pkg::ST_IDLE && !q.timed)
               begin
                  d.timed = 1'b1;
                  d.ms = {q.phi, rx.data};
                  d.mdiv = 18'(MS_CYC - 1);
               end
            end
            2'h3:
            begin
               d.limit = rx.data;
               d.pst = 2'h0;
            end
            default:
               d.pst = 2'h0;
         endcase
      end
      // exposure timer
      if (q.timed)
      begin
         if (q.mdiv != 18'h00000)
            d.mdiv = q.mdiv - 18'h00001;
         else
         begin
            d.mdiv = 18'(MS_CYC - 1);
            if (q.ms == 16'h0000)
               d.timed = 1'b0;
            else
               d.ms = q.ms - 16'h0001;
         end
      end
      // shutter sequence
      case (q.st)
         shc_pkg::ST_IDLE:
         begin
            if (ctl_fall || btn_rise || d.timed)
            begin
               d.st = shc_pkg::ST_OPENING;
               d.steps = 13'h0000;
               d.enc = 13'h0000;
               d.sdiv = 14'h0000;
            end
         end
         shc_pkg::ST_OPENING, shc_pkg::ST_CLOSING:
         begin
            // edges on the control line are simply not looked at here
            if (i_enc_pulse[mv])
               d.enc = q.enc + 13'h0001;
            if (q.steps == shc_pkg::TRAVEL_STEPS)
            begin
               d.sdiv = 14'h0000;
               d.steps = 13'h0000;
               d.enc = 13'h0000;
               if (shc_gap(shc_pkg::TRAVEL_STEPS, q.enc) > 13'(q.limit))
               begin
                  d.st = shc_pkg::ST_FAULT;
                  d.fatal = 1'b1;
                  d.derr[mv] = 1'b1;
               end
               else if (q.st == shc_pkg::ST_OPENING)
                  d.st = shc_pkg::ST_OPEN;
               else
               begin
                  d.st = shc_pkg::ST_IDLE;
                  d.lead = !q.lead;
                  d.dir = !q.dir;
               end
            end
            else if (q.sdiv == 14'(STEP_CYC - 1))
            begin
               d.sdiv = 14'h0000;
               d.step[mv] = 1'b1;
               d.steps = q.steps + 13'h0001;
            end
            else
               d.sdiv = q.sdiv + 14'h0001;
         end
         shc_pkg::ST_OPEN:
         begin
            if (!open_lvl)
               d.st = shc_pkg::ST_CLOSING;
         end
         shc_pkg::ST_FAULT:
            d.st = shc_pkg::ST_FAULT;
         default:
            d.st = shc_pkg::ST_IDLE;
      endcase
      // panel or serial reset returns every controller to rest
      if (restart)
      begin
         d.st = shc_pkg::ST_IDLE;
         d.fatal = 1'b0;
         d.derr = 2'b00;
         d.cerr = 1'b0;
         d.timed = 1'b0;
         d.pst = 2'h0;
         d.steps = 13'h0000;
         d.sdiv = 14'h0000;
      end
      // a framing error landing with a reset still counts
      if (ferr)
         d.cerr = 1'b1;
      d.cl_n[0] = !(d.st == shc_pkg::ST_IDLE && !d.lead);
      d.cl_n[1] = !(d.st == shc_pkg::ST_IDLE && d.lead);
   end

   // state register
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         q          <= '0;
         q.st       <= shc_pkg::ST_IDLE;
         q.limit    <= shc_pkg::LIMIT_RESET;
         q.ctl_prev <= 1'b1;
         q.ilk      <= 1'b1;
         q.cl_n     <= 2'b10;
      end
      else
         q <= d;
   end

   // outputs
   assign o_first_closed_n  = q.cl_n[0];
   assign o_second_closed_n = q.cl_n[1];
   assign o_fault_n         = !q.fatal;
   assign o_step            = q.step;
   assign o_dir             = q.dir;
   assign tx                = '{valid: q.txv, data: q.txb};
   assign o_lamps = '{interlock_lamp:          q.ilk,
                      comm_fault_lamp:         q.cerr,
                      second_drive_fault_lamp: q.derr[1],
                      first_drive_fault_lamp:  q.derr[0]};

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   open_hold_a : assert property ((q.st == shc_pkg::ST_OPEN && !ctl_lvl && !restart)
      |=> q.st == shc_pkg::ST_OPEN) else $error("shutter closed while held open");
   open_start_a : assert property ((q.st == shc_pkg::ST_IDLE && ctl_fall && !restart)
      |=> q.st == shc_pkg::ST_OPENING) else $error("falling edge did not open");
   close_start_a : assert property ((q.st == shc_pkg::ST_OPEN && !open_lvl && !restart)
      |=> q.st == shc_pkg::ST_CLOSING ##1 !o_step[q.lead] [*2])
      else $error("rising edge did not close");
   first_closed_a : assert property ((q.st == shc_pkg::ST_CLOSING && q.lead
      && q.steps == shc_pkg::TRAVEL_STEPS && !restart) |=> !o_first_closed_n
      || q.st == shc_pkg::ST_FAULT) else $error("first blade closed not shown");
   second_closed_a : assert property ((q.st == shc_pkg::ST_CLOSING && !q.lead
      && q.steps == shc_pkg::TRAVEL_STEPS && !restart) |=> !o_second_closed_n
      || q.st == shc_pkg::ST_FAULT) else $error("second blade closed not shown");
   fault_pin_a : assert property ($fell(o_fault_n) |-> $past(moving))
      else $error("fault raised outside a movement");
   fault_block_a : assert property ((q.st == shc_pkg::ST_FAULT && !restart)
      |=> q.st == shc_pkg::ST_FAULT && !o_fault_n) else $error("fault left");
   closing_deaf_a : assert property ((q.st == shc_pkg::ST_CLOSING && !restart)
      |=> q.st inside {shc_pkg::ST_CLOSING, shc_pkg::ST_IDLE, shc_pkg::ST_FAULT})
      else $error("closing interrupted");
   button_open_a : assert property ((q.st == shc_pkg::ST_IDLE && btn_rise && !restart)
      |=> q.st == shc_pkg::ST_OPENING) else $error("button did not open");
   limit_check_a : assert property ((moving && q.steps == shc_pkg::TRAVEL_STEPS
      && shc_gap(shc_pkg::TRAVEL_STEPS, q.enc) > 13'(q.limit) && !restart)
      |=> q.st == shc_pkg::ST_FAULT && !o_fault_n) else $error("mismatch missed");

endmodule

// ==== include/shc_pkg.sv ====
package shc_pkg;

   // clock and serial timing
   localparam int CLK_HZ       = 200_000_000;
   localparam int BAUD_HZ      = 19200;
   localparam int BAUD_CYC     = CLK_HZ / BAUD_HZ;
   localparam int DATA_BITS    = 8;
   localparam int STOP_BITS    = 1;

   // input filtering: edge must be seen well inside the poll budget
   localparam int POLL_NS      = 20000;
   localparam int DEB_NS       = 2000;
   localparam int DEB_CYC      = (DEB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // blade motion
   localparam int STEP_HZ      = 20000;
   localparam int STEP_CYC     = CLK_HZ / STEP_HZ;
   localparam int MS_CYC       = CLK_HZ / 1000;
   localparam logic [12:0] TRAVEL_STEPS = 13'h1137;
   localparam logic [7:0]  LIMIT_RESET  = 8'h18;

   // serial command bytes
   localparam logic [7:0] CMD_TIMED_EXPO = 8'h65;
   localparam logic [7:0] CMD_RESTART    = 8'h72;
   localparam logic [7:0] CMD_LIMIT      = 8'h74;
   localparam logic [7:0] CMD_STATUS     = 8'h73;
   localparam logic [7:0] REPLY_UNKNOWN  = 8'h3F;

   // status byte bit positions
   localparam int SB_FATAL     = 0;
   localparam int SB_DRV1      = 1;
   localparam int SB_DRV2      = 2;
   localparam int SB_COMM      = 3;
   localparam int SB_OPEN      = 4;
   localparam int SB_LEAD      = 5;

   typedef enum logic [4:0]
   {
      ST_IDLE    = 5'h01,
      ST_OPENING = 5'h02,
      ST_OPEN    = 5'h04,
      ST_CLOSING = 5'h08,
      ST_FAULT   = 5'h10
   } shc_state_t;

   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
   } shc_byte_t;

   typedef struct packed
   {
      logic interlock_lamp;
      logic comm_fault_lamp;
      logic second_drive_fault_lamp;
      logic first_drive_fault_lamp;
   } shc_lamps_t;

endpackage

// ==== core/shc_filter.sv ====
`timescale 1ns/1ps
// two-flop synchroniser plus stability filter
module shc_filter #(
   parameter logic RST_LVL = 1'b1
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // raw and filtered level
   input  wire logic i_raw,
   output logic      o_lvl
);

   typedef struct packed
   {
      logic       s1;
      logic       s2;
      logic       lvl;
      logic [8:0] cnt;
   } shc_flt_t;

   shc_flt_t q;
   shc_flt_t d;

   // new level accepted only after it stayed put for the whole window
   always_comb
   begin
      d = q;
      d.s1 = i_raw;
      d.s2 = q.s1;
      if (q.s2 == q.lvl)
         d.cnt = 9'h000;
      else if (q.cnt == 9'(shc_pkg::DEB_CYC - 1))
      begin
         d.lvl = q.s2;
         d.cnt = 9'h000;
      end
      else
         d.cnt = q.cnt + 9'h001;
   end

   // state register
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         q     <= '0;
         q.s1  <= RST_LVL;
         q.s2  <= RST_LVL;
         q.lvl <= RST_LVL;
      end
      else
         q <= d;
   end

   assign o_lvl = q.lvl;

endmodule

// ==== core/shc_uart.sv ====
`timescale 1ns/1ps
// 8N1 receiver and transmitter, no flow control
module shc_uart #(
   parameter int BAUD_CYC = shc_pkg::BAUD_CYC
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   // serial pins
   input  wire logic              i_rxd,
   output logic                   o_txd,
   // received bytes
   output shc_pkg::shc_byte_t     o_rx,
   output logic                   o_frame_err,
   // bytes to send
   input  wire shc_pkg::shc_byte_t i_tx,
   output logic                   o_tx_ready
);

   typedef struct packed
   {
      logic       rs1;
      logic       rs2;
      logic       rbusy;
      logic [13:0] rcnt;
      logic [3:0] rbit;
      logic [7:0] rsh;
      logic       rvalid;
      logic       ferr;
      logic       tbusy;
      logic [13:0] tcnt;
      logic [3:0] tbit;
      logic [9:0] tsh;
      logic       txd;
   } shc_uart_t;

   localparam logic [13:0] FULL = 14'(BAUD_CYC - 1);
   localparam logic [13:0] HALF = 14'(BAUD_CYC / 2 - 1);

   shc_uart_t q;
   shc_uart_t d;

   // receiver samples mid-bit, transmitter shifts start, data, stop
   always_comb
   begin
      d = q;
      d.rvalid = 1'b0;
      d.ferr = 1'b0;
      d.rs1 = i_rxd;
      d.rs2 = q.rs1;
      if (!q.rbusy)
      begin
         if (!q.rs2)
         begin
            d.rbusy = 1'b1;
            d.rcnt = HALF;
            d.rbit = 4'h0;
         end
      end
      else if (q.rcnt != 14'h0000)
         d.rcnt = q.rcnt - 14'h0001;
      else
      begin
         d.rcnt = FULL;
         d.rbit = q.rbit + 4'h1;
         if (q.rbit == 4'h0)
            d.rbusy = !q.rs2; // glitch, not a start bit
         else if (q.rbit == 4'h9)
         begin
            d.rbusy = 1'b0;
            d.rvalid = q.rs2;
            d.ferr = !q.rs2;
         end
         else
            d.rsh = {q.rs2, q.rsh[7:1]};
      end
      if (!q.tbusy)
      begin
         if (i_tx.valid)
         begin
            d.tbusy = 1'b1;
            d.tsh = {1'b1, i_tx.data, 1'b0};
            d.tcnt = FULL;
            d.tbit = 4'h0;
         end
      end
      else if (q.tcnt != 14'h0000)
         d.tcnt = q.tcnt - 14'h0001;
      else
      begin
         d.tcnt = FULL;
         d.tsh = {1'b1, q.tsh[9:1]};
         d.tbit = q.tbit + 4'h1;
         if (q.tbit == 4'h9)
            d.tbusy = 1'b0;
      end
      d.txd = d.tbusy ? d.tsh[0] : 1'b1;
   end

   // state register
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         q     <= '0;
         q.rs1 <= 1'b1;
         q.rs2 <= 1'b1;
         q.txd <= 1'b1;
      end
      else
         q <= d;
   end

   // outputs
   assign o_txd       = q.txd;
   assign o_rx        = '{valid: q.rvalid, data: q.rsh};
   assign o_frame_err = q.ferr;
   assign o_tx_ready  = !q.tbusy;

endmodule

// ==== dv/shc_mech_model.sv ====
`timescale 1ns/1ps
// blade mechanics: each step comes back as one encoder increment
module shc_mech_model (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   // drive side
   input  wire logic [1:0] i_step,
   input  wire logic       i_stall,
   // encoder side
   output logic [1:0]      o_enc_pulse
);
   // a stalled blade gives no increments at all
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_enc_pulse <= 2'h0;
      else
         o_enc_pulse <= i_stall ? 2'h0 : i_step;
   end
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("unexpected %s exp=%0h got=%0h", nm, ex, got); end end
module testbench;
   typedef struct packed {logic [7:0] cmd; logic [7:0] rep;} shc_tb_row_t;
   localparam int BC = 16;
   // design connections
   logic                i_clk, i_arst_n, i_open_close_n, i_open_btn, i_reset_btn;
   logic                i_cable_secure, i_rxd, stall;
   logic                o_first_closed_n, o_second_closed_n, o_fault_n, o_dir, o_txd;
   logic [1:0]          o_step, enc;
   shc_pkg::shc_lamps_t o_lamps;
   int                  n_mismatch, checks, n_step0, t;
   logic [7:0]          rep;
   wire  [2:0]          obs = {o_fault_n, o_second_closed_n, o_first_closed_n};
   shc_tb_row_t         rows [3] = '{'{shc_pkg::CMD_STATUS, 8'h00},
                                     '{8'h41, shc_pkg::REPLY_UNKNOWN},
                                     '{shc_pkg::CMD_STATUS, 8'h01 << shc_pkg::SB_COMM}};

   shc_shutter_controller #(.BAUD_CYC(BC), .STEP_CYC(2), .MS_CYC(50)) u_dut (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_open_close_n(i_open_close_n),
      .o_first_closed_n(o_first_closed_n), .o_second_closed_n(o_second_closed_n),
      .o_fault_n(o_fault_n), .i_open_btn(i_open_btn), .i_reset_btn(i_reset_btn),
      .i_cable_secure(i_cable_secure), .o_lamps(o_lamps), .o_step(o_step), .o_dir(o_dir),
      .i_enc_pulse(enc), .i_rxd(i_rxd), .o_txd(o_txd));

   shc_mech_model u_mech (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_step(o_step), .i_stall(stall),
      .o_enc_pulse(enc));

   // 200 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // count step pulses of the first blade, away from the edge that launches them
   always @(negedge i_clk)
      if (o_step[0] === 1'b1) n_step0++;

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic timeout(input string nm);
      n_mismatch++;
      $display("unexpected %s exp=done got=timeout", nm);
      report_and_stop;
   endtask

   // wait until the masked control outputs match, within a bound
   task automatic wait_obs(input logic [2:0] m, input logic [2:0] w, input int bound);
      t = 0;
      while ((obs & m) !== w)
      begin
         if (t >= bound) timeout("control outputs");
         cyc(1);
         t++;
      end
   endtask

   // host sends one 8N1 byte, lsb first, holding the stop bit one full bit time
   task automatic send(input logic [7:0] b);
      i_rxd = 1'b0;
      cyc(BC);
      for (int k = 0; k < 8; k++)
      begin
         i_rxd = b[k];
         cyc(BC);
      end
      i_rxd = 1'b1;
      cyc(BC);
   endtask

   // host receives one reply byte, sampled mid-bit
   task automatic recv(output logic [7:0] b);
      int w;
      w = 0;
      while (o_txd !== 1'b0)
      begin
         if (w >= 4 * BC) timeout("reply start");
         cyc(1);
         w++;
      end
      cyc(BC / 2);
      for (int k = 0; k < 8; k++)
      begin
         cyc(BC);
         b[k] = o_txd;
      end
      cyc(BC);
      `CHK("stop bit", 1'b1, o_txd)
   endtask

   // main sequence
   initial
   begin
      i_arst_n = 1'b0; i_open_close_n = 1'b1; i_open_btn = 1'b0; i_reset_btn = 1'b0;
      i_cable_secure = 1'b0; i_rxd = 1'b1; stall = 1'b0;
      n_mismatch = 0; checks = 0; n_step0 = 0;
      repeat (6) @(posedge i_clk);
      `CHK("closed_n", 2'b10, obs[1:0])
      `CHK("fault_n", 1'b1, o_fault_n)
      `CHK("dir", 1'b0, o_dir)
      `CHK("txd idle", 1'b1, o_txd)
      @(negedge i_clk);
      i_arst_n = 1'b1;
      cyc(3);
      `CHK("interlock lamp", 1'b1, o_lamps.interlock_lamp)
      i_cable_secure = 1'b1;
      cyc(3);
      `CHK("interlock lamp", 1'b0, o_lamps.interlock_lamp)
      $display("test reset done");
      // ordinary serial commands from the row table
      foreach (rows[r])
      begin
         send(rows[r].cmd);
         recv(rep);
         `CHK("reply", rows[r].rep, rep)
      end
      `CHK("comm lamp", 1'b1, o_lamps.comm_fault_lamp)
      send(shc_pkg::CMD_RESTART);
      cyc(40);
      `CHK("comm lamp", 1'b0, o_lamps.comm_fault_lamp)
      // the limit operand byte must not be taken as a command of its own
      send(shc_pkg::CMD_LIMIT);
      send(shc_pkg::LIMIT_RESET);
      cyc(40);
      `CHK("limit operand", 1'b0, o_lamps.comm_fault_lamp)
      $display("test serial done");
      // a short low pulse on the control line must not open
      i_open_close_n = 1'b0;
      cyc(100);
      i_open_close_n = 1'b1;
      cyc(600);
      `CHK("glitch ignored", 3'b110, obs)
      $display("test glitch done");
      // exposure on the control line, with noise during closing
      n_step0 = 0;
      i_open_close_n = 1'b0;
      wait_obs(3'b111, 3'b111, 4000);
      cyc(10000);
      `CHK("open held", 3'b111, obs)
      `CHK("first blade steps", shc_pkg::TRAVEL_STEPS, 13'(n_step0))
      i_open_close_n = 1'b1;
      cyc(1000);
      i_open_close_n = 1'b0;
      cyc(500);
      i_open_close_n = 1'b1;
      wait_obs(3'b111, 3'b101, 20000);
      `CHK("second closed_n", 1'b0, o_second_closed_n)
      cyc(1000);
      `CHK("no reopen", 3'b101, obs)
      `CHK("dir after close", 1'b1, o_dir)
      $display("test exposure done");
      // stalled blade during a button exposure gives a fatal error
      stall = 1'b1;
      i_open_btn = 1'b1;
      wait_obs(3'b111, 3'b011, 20000);
      `CHK("second drive lamp", 1'b1, o_lamps.second_drive_fault_lamp)
      `CHK("first drive lamp", 1'b0, o_lamps.first_drive_fault_lamp)
      i_open_btn = 1'b0;
      stall = 1'b0;
      i_open_close_n = 1'b0;
      cyc(1000);
      `CHK("blocked", 3'b011, obs)
      i_open_close_n = 1'b1;
      cyc(500);
      i_reset_btn = 1'b1;
      wait_obs(3'b100, 3'b100, 1000);
      i_reset_btn = 1'b0;
      cyc(500);
      `CHK("drive lamp clear", 1'b0, o_lamps.second_drive_fault_lamp)
      $display("test fault done");
      // operation resumes with the open button
      i_open_btn = 1'b1;
      wait_obs(3'b111, 3'b111, 4000);
      cyc(10000);
      `CHK("open by button", 3'b111, obs)
      i_open_btn = 1'b0;
      wait_obs(3'b111, 3'b110, 20000);
      `CHK("dir back", 1'b0, o_dir)
      $display("test resume done");
      // a 2 ms timed exposure runs one whole open-close cycle by itself
      n_step0 = 0;
      send(shc_pkg::CMD_TIMED_EXPO);
      send(8'h00);
      send(8'h02);
      wait_obs(3'b111, 3'b111, 100);
      wait_obs(3'b111, 3'b101, 20000);
      `CHK("timed steps", shc_pkg::TRAVEL_STEPS, 13'(n_step0))
      `CHK("dir timed", 1'b1, o_dir)
      $display("test timed done");
      report_and_stop;
   end
endmodule
